// ### hdl/ect_map.vh
// Notes on behaviour
// - pin source counts only the chosen edge: falling, rising or both
// - neighbour source counts neighbour channel overflow/underflow pulses
// - phase-shift clock of I/O group zero can be chosen as event source
// - each event decrements; on underflow reload and continue counting
// - any 16-bit setting n gives one underflow per n+1 events
// - counting starts when run bit is set to 1
// - counting stops while run bit is 0
// - every underflow raises the interrupt request
// - pin is a plain port or the event input
// - reading the count register returns the live counter
// - write loads reload and counter when stopped or before first event
// - write while running loads reload only; counter takes it at reload
// - mode field bits 1:0 equal to 01 selects event counter mode
// - polarity bits 3:2: 00 falling, 01 rising, 10 both, 11 unused
// - polarity only matters when event clock select is 0
// - channels 0,2-5: select 0 is pin, 1 is neighbour pulse
// - channel 1: select 0 uses source register choice, 1 neighbour
// - bit 4 stored on channels 0 and 3 only, written 0
// - bit 5 has no function, written 0, reads undefined; here it is stored as 0 and always reads 0
// - bit 6 accepts any value with no effect
`ifndef ECT_MAP_VH
`define ECT_MAP_VH
`define ECT_ADDR_MODE 12'h000
`define ECT_ADDR_COUNT 12'h004
`define ECT_ADDR_START 12'h008
`define ECT_ADDR_SRCSEL 12'h00C
`define ECT_MODE_EVENT 2'h1
`define ECT_POL_FALL 2'h0
`define ECT_POL_RISE 2'h1
`define ECT_POL_BOTH 2'h2
`define ECT_BIT_OPLO 0
`define ECT_BIT_OPHI 1
`define ECT_BIT_POLLO 2
`define ECT_BIT_POLHI 3
`define ECT_BIT_RES4 4
`define ECT_BIT_UNUSED5 5
`define ECT_BIT_UNUSED6 6
`define ECT_BIT_ECS 7
`define ECT_MODE_RESET 8'h00
`define ECT_COUNT_RESET 16'h0000
`endif

// ### hdl/ect_event_counter_timer.v
`timescale 1ns/1ns
`include "ect_map.vh"
module ect_event_counter_timer #(
	parameter CHANNEL_INDEX = 1
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// event sources
	input wire eventInputPin,
	input wire phaseShiftClk,
	input wire neighbourPulse,
	// event outputs
	output reg underflowIrq,
	output reg cascadeOut,
	output reg channelRunBit
);
	function edgeHit;
		input [1:0] pol;
		input rise;
		input fall;
		begin
			case (pol)
				`ECT_POL_FALL: edgeHit = fall;
				`ECT_POL_RISE: edgeHit = rise;
				`ECT_POL_BOTH: edgeHit = rise | fall;
				default: edgeHit = 1'b0;
			endcase
		end
	endfunction

	localparam HAS_RES4 = (CHANNEL_INDEX == 0) || (CHANNEL_INDEX == 3);
	localparam HAS_SRCSEL = (CHANNEL_INDEX == 1);

	// pin and phase clock both come from outside the clock domain
	wire [1:0] rawIn;
	wire [1:0] syncOut;
	reg [1:0] prevSync_reg;
	assign rawIn = {phaseShiftClk, eventInputPin};
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gSync
			reg meta_reg;
			reg stable_reg;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_reg <= 1'b0;
					stable_reg <= 1'b0;
				end else begin
					meta_reg <= rawIn[g];
					stable_reg <= meta_reg;
				end
			end
			assign syncOut[g] = stable_reg;
		end
	endgenerate

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			prevSync_reg <= 2'h0;
		else
			prevSync_reg <= syncOut;
	end

	wire [1:0] riseHit = syncOut & ~prevSync_reg;
	wire [1:0] fallHit = ~syncOut & prevSync_reg;

	reg [7:0] mode_reg;
	reg srcSel_reg;
	reg [15:0] reload_reg;
	reg [15:0] count_reg;
	reg seenEvent_reg;

	wire [1:0] opMode = mode_reg[`ECT_BIT_OPHI:`ECT_BIT_OPLO];
	wire [1:0] polarity = mode_reg[`ECT_BIT_POLHI:`ECT_BIT_POLLO];
	wire eventClockSelect = mode_reg[`ECT_BIT_ECS];
	// phase clock only reachable on the channel with a source register
	wire usePhase = HAS_SRCSEL && srcSel_reg;
	wire pinEdge = edgeHit(polarity, riseHit[0], fallHit[0]);
	wire phaseEdge = edgeHit(polarity, riseHit[1], fallHit[1]);
	reg rawEvent;
	always @* begin
		if (eventClockSelect)
			rawEvent = neighbourPulse;
		else if (usePhase)
			rawEvent = phaseEdge;
		else
			rawEvent = pinEdge;
	end
	// bit 6 and bit 5 never reach this term
	wire counting = channelRunBit && (opMode == `ECT_MODE_EVENT);
	wire countEvent = counting && rawEvent;
	wire atZero = (count_reg == 16'h0000);

	// apb decode
	wire setupPhase = psel && !penable;
	wire accessDone = psel && penable && pready;
	wire wrDone = accessDone && pwrite;
	wire addrMode = (paddr == `ECT_ADDR_MODE);
	wire addrCount = (paddr == `ECT_ADDR_COUNT);
	wire addrStart = (paddr == `ECT_ADDR_START);
	wire addrSrc = (paddr == `ECT_ADDR_SRCSEL);
	wire addrHit = addrMode | addrCount | addrStart | addrSrc;
	wire countWrite = wrDone && addrCount;
	// loading the counter directly is only safe before events flow
	wire loadBoth = countWrite && (!channelRunBit || !seenEvent_reg);

	reg [7:0] modeRead;
	always @* begin
		modeRead = mode_reg;
		modeRead[`ECT_BIT_UNUSED5] = 1'b0;
		if (!HAS_RES4)
			modeRead[`ECT_BIT_RES4] = 1'b0;
	end

	reg [31:0] readMux;
	always @* begin
		readMux = 32'h0000_0000;
		if (addrMode)
			readMux = {24'h000000, modeRead};
		else if (addrCount)
			readMux = {16'h0000, count_reg};
		else if (addrStart)
			readMux = {31'h0000_0000, channelRunBit};
		else if (addrSrc)
			readMux = {31'h0000_0000, srcSel_reg};
	end

	// one wait-free answer: ready raised in the access cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setupPhase;
			if (setupPhase) begin
				pslverr <= !addrHit;
				prdata <= pwrite ? 32'h0000_0000 : readMux;
			end else begin
				pslverr <= 1'b0;
				prdata <= 32'h0000_0000;
			end
		end
	end

	// control registers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= `ECT_MODE_RESET;
			srcSel_reg <= 1'b0;
			channelRunBit <= 1'b0;
		end else if (wrDone) begin
			if (addrMode) begin
				mode_reg <= pwdata[7:0];
				mode_reg[`ECT_BIT_UNUSED5] <= 1'b0;
				if (!HAS_RES4)
					mode_reg[`ECT_BIT_RES4] <= 1'b0;
			end
			if (addrStart)
				channelRunBit <= pwdata[0];
			if (addrSrc && HAS_SRCSEL)
				srcSel_reg <= pwdata[0];
		end
	end

	// counter core
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reload_reg <= `ECT_COUNT_RESET;
			count_reg <= `ECT_COUNT_RESET;
			seenEvent_reg <= 1'b0;
			underflowIrq <= 1'b0;
			cascadeOut <= 1'b0;
		end else begin
			underflowIrq <= 1'b0;
			cascadeOut <= 1'b0;
			if (countWrite)
				reload_reg <= pwdata[15:0];
			if (!channelRunBit)
				seenEvent_reg <= 1'b0;
			else if (countEvent)
				seenEvent_reg <= 1'b1;
			if (loadBoth) begin
				count_reg <= pwdata[15:0];
			end else if (countEvent) begin
				if (atZero) begin
					count_reg <= reload_reg;
					underflowIrq <= 1'b1;
					cascadeOut <= 1'b1;
				end else begin
					count_reg <= count_reg - 16'h0001;
				end
			end
		end
	end
endmodule // ect_event_counter_timer

// ### tb/ect_checker.sv
`timescale 1ns/1ns
module ect_checker (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// events
	input wire underflowIrq,
	input wire cascadeOut,
	input wire channelRunBit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_irq_cascade: assert property (underflowIrq == cascadeOut)
		else $error("irq and cascade differ");
	chk_stop_quiet: assert property (!$past(channelRunBit) |-> !underflowIrq)
		else $error("irq while stopped");
	chk_run_write: assert property ($rose(channelRunBit) |->
		$past(pready && pwrite && paddr == 12'h008)) else $error("run set alone");
	chk_run_clear: assert property ($fell(channelRunBit) |->
		$past(pready && pwrite && paddr == 12'h008)) else $error("run lost");
	chk_ready_setup: assert property (pready == $past(psel && !penable))
		else $error("pready not after setup");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("pready held");
	chk_slverr_ready: assert property (pslverr |-> pready)
		else $error("slverr without pready");
	chk_prdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata outside access");
endmodule // ect_checker
bind ect_event_counter_timer ect_checker i_chk (.clk(clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.underflowIrq(underflowIrq), .cascadeOut(cascadeOut),
	.channelRunBit(channelRunBit));

// ### tb/ect_event_source.sv
`timescale 1ns/1ns
module ect_event_source (
	// clock
	input wire clk,
	// event lines
	output logic eventInputPin,
	output logic neighbourPulse,
	output logic phaseShiftClk
);
	// phase clock starts low: both-edge use never set up with it
	initial begin
		eventInputPin = 1'h1;
		neighbourPulse = 1'h0;
		phaseShiftClk = 1'h0;
	end
	// three cycles apart so the synchroniser sees every level
	task automatic pinEdges(input int n);
		repeat (n) begin
			eventInputPin <= !eventInputPin;
			repeat (3) @(posedge clk);
		end
	endtask
	task automatic phaseEdges(input int n);
		repeat (n) begin
			phaseShiftClk <= !phaseShiftClk;
			repeat (3) @(posedge clk);
		end
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			neighbourPulse <= 1'h1;
			@(posedge clk);
			neighbourPulse <= 1'h0;
			@(posedge clk);
		end
	endtask
endmodule // ect_event_source

// ### tb/ect_tb.sv
`timescale 1ns/1ns
module tb;
	logic clk, rst_n, psel, penable, pwrite, se, pready, pslverr;
	logic irq, casc, runBit, pin, nbr, phs;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int err_total, checked, irqs, cascs, cyc;
	ect_event_counter_timer i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.eventInputPin(pin), .phaseShiftClk(phs), .neighbourPulse(nbr),
		.underflowIrq(irq), .cascadeOut(casc), .channelRunBit(runBit));
	ect_event_source i_src (.clk(clk), .eventInputPin(pin),
		.neighbourPulse(nbr), .phaseShiftClk(phs));
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	task automatic finish_test();
		$display("checked %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (irq === 1'h1)
			irqs <= irqs + 1;
		if (casc === 1'h1)
			cascs <= cascs + 1;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, s);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		q = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input string n, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(n, e, q);
	endtask
	initial begin
		rst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rd("mode", 12'h000, 32'h0);
		rd("count", 12'h004, 32'h0);
		apb(1'h1, 12'h010, 32'h1);
		chk("slverr", 32'h1, {31'h0, se});
		// neighbour source, bit 6 set to show it is inert
		apb(1'h1, 12'h000, 32'hC1);
		apb(1'h1, 12'h004, 32'h2);
		rd("count", 12'h004, 32'h2);
		apb(1'h1, 12'h008, 32'h1);
		rd("run", 12'h008, 32'h1);
		i_src.pulses(1);
		apb(1'h1, 12'h004, 32'h5);
		rd("count", 12'h004, 32'h1);
		i_src.pulses(2);
		rd("count", 12'h004, 32'h5);
		chk("irqs", 32'h1, irqs);
		chk("cascade", 32'h1, cascs);
		apb(1'h1, 12'h008, 32'h0);
		i_src.pulses(2);
		rd("count", 12'h004, 32'h5);
		for (int p = 0; p < 3; p++) begin
			apb(1'h1, 12'h008, 32'h0);
			apb(1'h1, 12'h000, 32'h1 | (p << 2));
			apb(1'h1, 12'h004, 32'hFFFF);
			apb(1'h1, 12'h008, 32'h1);
			i_src.pinEdges(4);
			rd("count", 12'h004, p == 2 ? 32'hFFFB : 32'hFFFD);
		end
		// phase clock source, rising edges only
		apb(1'h1, 12'h008, 32'h0);
		apb(1'h1, 12'h00C, 32'h1);
		rd("srcsel", 12'h00C, 32'h1);
		apb(1'h1, 12'h000, 32'h5);
		apb(1'h1, 12'h004, 32'h3);
		apb(1'h1, 12'h008, 32'h1);
		i_src.phaseEdges(4);
		rd("phase", 12'h004, 32'h1);
		finish_test();
	end
endmodule // tb
